// *** bench/fault_mask_safe_mode_ctrl_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module fault_safe_props
    import fault_safe_pkg::*;
(
    // Clock and reset
    input wire logic     clk_sys,
    input wire logic     arst_n,
    // Register port
    input wire reg_req_s reg_req,
    input wire reg_rsp_s reg_rsp,
    // Alarm and mode outputs
    input wire logic     alarm_o,
    input wire logic     alarm_n_o,
    input wire logic     safe_mode_o,
    input wire logic     severe_mode_o,
    input wire logic     outputs_tristate_o
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    chk_ack_cause: assert property (reg_rsp.ack |->
        $past(reg_req.rd | reg_req.wr) && !$past(severe_mode_o)) else $error("ack not caused");
    chk_rdata_idle: assert property (!reg_rsp.ack |-> reg_rsp.rdata == 16'h0000)
        else $error("rdata without ack");
    chk_severe_dark: assert property (severe_mode_o |=> !alarm_o && !alarm_n_o)
        else $error("alarm pair not low in severe mode");
    chk_alarm_pair: assert property (!severe_mode_o && !$past(severe_mode_o) |->
        alarm_n_o != alarm_o) else $error("alarm pair not complementary");
    chk_severe_safe: assert property (severe_mode_o && $past(severe_mode_o) |->
        safe_mode_o) else $error("severe without safe mode");
    chk_severe_tri: assert property (severe_mode_o && $past(severe_mode_o) |->
        !outputs_tristate_o) else $error("tristate during severe mode");
    chk_force_on: assert property ((reg_req.wr && reg_req.addr == ADDR_FORCED_SAFE
        && reg_req.wdata == FORCED_SAFE_KEY) ##1 reg_rsp.ack |=>
        severe_mode_o || (safe_mode_o && outputs_tristate_o)) else $error("key did not force");
    chk_force_off: assert property ((reg_req.wr && reg_req.addr == ADDR_FORCED_SAFE
        && reg_req.wdata != FORCED_SAFE_KEY) ##1 reg_rsp.ack |=> !outputs_tristate_o)
        else $error("forced mode not left");
    chk_safe_read: assert property ((reg_req.rd && reg_req.addr == ADDR_SAFE_STATUS)
        ##1 (reg_rsp.ack && $stable(safe_mode_o)) |-> reg_rsp.rdata == {15'h0000, safe_mode_o})
        else $error("safe status read wrong");
endmodule : fault_safe_props

bind fault_mask_safe_mode_ctrl fault_safe_props fault_safe_props_i (
    .clk_sys(clk_sys), .arst_n(arst_n), .reg_req(reg_req), .reg_rsp(reg_rsp),
    .alarm_o(alarm_o), .alarm_n_o(alarm_n_o), .safe_mode_o(safe_mode_o),
    .severe_mode_o(severe_mode_o), .outputs_tristate_o(outputs_tristate_o));
`default_nettype wire

// *** bench/test_fault_mask_safe_mode_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_fault_mask_safe_mode_ctrl;
    import fault_safe_pkg::*;
    logic        clk_sys, arst_n, fast, wd_ref_clk, got;
    logic        alarm_o, alarm_n_o, safe_mode_o, severe_mode_o, outputs_tristate_o;
    logic [3:0]  sup;
    logic [15:0] g3, rd_v;
    reg_req_s    req;
    reg_rsp_s    rsp;
    int          n_errors, checks_done, m;
    int          crit_pos[5] = '{CRIT_IO_OVER, CRIT_IO_UNDER, CRIT_CORE_OVER,
                                 CRIT_CORE_UNDER, CRIT_CLK_FAULT};

    fault_mask_safe_mode_ctrl fault_mask_safe_mode_ctrl_i (.clk_sys(clk_sys), .arst_n(arst_n),
        .reg_req(req), .reg_rsp(rsp), .g3_fault_in(g3), .io_supply_over(sup[0]),
        .io_supply_under(sup[1]), .core_supply_over(sup[2]), .core_supply_under(sup[3]),
        .wd_ref_clk(wd_ref_clk), .alarm_o(alarm_o), .alarm_n_o(alarm_n_o),
        .safe_mode_o(safe_mode_o), .severe_mode_o(severe_mode_o),
        .outputs_tristate_o(outputs_tristate_o));
    wd_ref_model wd_ref_model_i (.fast(fast), .ref_clk(wd_ref_clk));

    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic give_verdict;
        $display("errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : give_verdict

    // Answer lands one edge after the request edge
    task automatic access(input logic w, input logic r, input logic [11:0] a,
                          input logic [15:0] d);
        @(posedge clk_sys);
        req <= '{wr: w, rd: r, addr: a, wdata: d};
        @(posedge clk_sys);
        req <= '0;
        #1;
        got = rsp.ack;
        rd_v = rsp.rdata;
    endtask : access

    task automatic wait_sev(input logic v, input int lim);
        for (int i = 0; i < lim && severe_mode_o !== v; i++) begin
            @(posedge clk_sys);
            #1;
        end
        if (severe_mode_o !== v) begin
            n_errors++;
            $display("Error at %0t: severe mode wait ran out", $time);
            give_verdict();
        end
    endtask : wait_sev

    initial begin
        arst_n = 1'b0;
        fast = 1'b0;
        sup = 4'h0;
        g3 = 16'h0000;
        req = '0;
        n_errors = 0;
        checks_done = 0;
        m = $urandom(64);
        repeat (2) @(posedge clk_sys);
        arst_n <= 1'b1;
        access(1'b0, 1'b1, ADDR_G3_MASK, 16'h0000);
        check(rd_v, G3_MASK_RESET);
        access(1'b1, 1'b1, 12'h2a0, 16'hffff);
        check({got, rd_v[14:0]}, 16'h8000);
        for (int b = 0; b < 16; b++) begin
            m = (b == 0) ? 32'hffff : $urandom;
            access(1'b1, 1'b0, ADDR_G3_MASK, m[15:0]);
            @(posedge clk_sys);
            g3 <= 16'h0001 << b;
            @(posedge clk_sys);
            g3 <= 16'h0000;
            repeat (3) @(posedge clk_sys);
            #1;
            check(alarm_o, !(G3_FLAGGED[b] && m[b]));
            check(alarm_n_o, G3_FLAGGED[b] && m[b]);
            check(safe_mode_o, !m[b]);
            access(1'b0, 1'b1, ADDR_SAFE_STATUS, 16'h0000);
            check(rd_v, {15'h0000, !m[b]});
            access(1'b0, 1'b1, ADDR_G3_STATUS, 16'h0000);
            check(rd_v, 16'h0001 << b);
            access(1'b1, 1'b0, ADDR_G3_CLEAR, 16'h0001 << b);
            repeat (3) @(posedge clk_sys);
            #1;
            check({alarm_o, safe_mode_o}, 16'h0000);
        end
        access(1'b1, 1'b0, ADDR_FORCED_SAFE, FORCED_SAFE_KEY);
        access(1'b0, 1'b1, ADDR_FORCED_SAFE, 16'h0000);
        check(rd_v, FORCED_SAFE_KEY);
        check({outputs_tristate_o, safe_mode_o}, 16'h0003);
        access(1'b1, 1'b0, ADDR_FORCED_SAFE, FORCED_SAFE_KEY ^ (16'h0001 << $urandom_range(15, 0)));
        @(posedge clk_sys);
        #1;
        check({outputs_tristate_o, safe_mode_o}, 16'h0000);
        access(1'b1, 1'b0, ADDR_FORCED_SAFE, FORCED_SAFE_KEY);
        @(posedge clk_sys);
        arst_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        arst_n <= 1'b1;
        access(1'b0, 1'b1, ADDR_FORCED_SAFE, 16'h0000);
        check(rd_v, FORCED_SAFE_RESET);
        check(outputs_tristate_o, 16'h0000);
        for (int k = 0; k < 5; k++) begin
            access(1'b1, 1'b0, ADDR_G3_MASK, 16'h1234);
            @(posedge clk_sys);
            if (k < 4)
                sup[k] <= 1'b1;
            else
                fast <= 1'b1;
            wait_sev(1'b1, 400);
            repeat (2) @(posedge clk_sys);
            #1;
            check({alarm_o, alarm_n_o}, 16'h0000);
            access(1'b1, 1'b1, ADDR_G3_MASK, 16'h00ff);
            check(got, 1'b0);
            @(posedge clk_sys);
            sup <= 4'h0;
            fast <= 1'b0;
            wait_sev(1'b0, 1200);
            repeat (2) @(posedge clk_sys);
            #1;
            check({alarm_o, alarm_n_o}, 16'h0002);
            access(1'b0, 1'b1, ADDR_CRIT_STATUS, 16'h0000);
            check(rd_v, 16'h0001 << crit_pos[k]);
            access(1'b0, 1'b1, ADDR_G3_MASK, 16'h0000);
            check(rd_v, 16'h0000);
            access(1'b1, 1'b0, ADDR_CRIT_CLEAR, 16'hffff);
            access(1'b0, 1'b1, ADDR_CRIT_STATUS, 16'h0000);
            check(rd_v, 16'h0000);
        end
        give_verdict();
    end
endmodule : test_fault_mask_safe_mode_ctrl
`default_nettype wire

// *** bench/wd_ref_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module wd_ref_model (
    // Rate select and reference output
    input  wire logic fast,
    output logic      ref_clk
);
    // Fast mode shrinks the interval below the watchdog minimum
    initial begin
        ref_clk = 1'b0;
        forever #((fast === 1'b1) ? 300 : 1000) ref_clk = ~ref_clk;
    end
endmodule : wd_ref_model
`default_nettype wire

// *** src/fault_mask_safe_mode_ctrl.sv ***
// Behaviour
// - Unmasked latched group-three fault puts device into safe mode.
// - Group-three fault raises alarm, drops complement; unflagged bits ignore mask.
// - Flagged bits 0-5,7 with mask set: no alarm, no safe mode.
// - All group-three mask bits reset to zero.
// - Critical fault places device in severe safe mode.
// - Critical fault wipes all registers but critical status; both alarms low.
// - During critical fault register accesses are refused.
// - Recovery shown by alarm high; critical status then readable.
// - Writing critical clear bit clears same critical status bit.
// - Critical bits 0,1 latch I/O supply over/under; 2,6-15 unused.
// - Clock watchdog sets critical bit 3 on slow system clock.
// - Critical bits 4,5 latch core supply over/under.
// - Writing 0xC3 at 0x10E forces safe mode, tri-stating outputs.
// - Any other value or reset ends forced safe mode.
// - Safe status bit 0 reads one while in safe mode.
`timescale 1ns/1ps
`default_nettype none
module fault_mask_safe_mode_ctrl
    import fault_safe_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        arst_n,
    // Register port from the serial link decoder
    input  wire reg_req_s    reg_req,
    output var  reg_rsp_s    reg_rsp,
    // Group-three fault events, same clock
    input  wire logic [15:0] g3_fault_in,
    // Supply monitors and watchdog reference, asynchronous
    input  wire logic        io_supply_over,
    input  wire logic        io_supply_under,
    input  wire logic        core_supply_over,
    input  wire logic        core_supply_under,
    input  wire logic        wd_ref_clk,
    // Alarm pair and safe-mode state
    output logic             alarm_o,
    output logic             alarm_n_o,
    output logic             safe_mode_o,
    output logic             severe_mode_o,
    output logic             outputs_tristate_o
);

    localparam int N_ASYNC = 5;

    // Three-stage synchronisers; value taken once stages two and three agree
    logic [N_ASYNC-1:0] async_in;
    logic [N_ASYNC-1:0] sync1_q;
    logic [N_ASYNC-1:0] sync2_q;
    logic [N_ASYNC-1:0] sync3_q;
    logic [N_ASYNC-1:0] filt_q;
    logic [N_ASYNC-1:0] filt_d;

    assign async_in = {wd_ref_clk, core_supply_under, core_supply_over,
                       io_supply_under, io_supply_over};

    genvar gi;
    generate
        for (gi = 0; gi < N_ASYNC; gi++) begin : g_sync
            always_comb begin
                filt_d[gi] = (sync2_q[gi] == sync3_q[gi]) ? sync3_q[gi] : filt_q[gi];
            end
            always_ff @(posedge clk_sys or negedge arst_n) begin
                if (!arst_n) begin
                    sync1_q[gi] <= 1'b0;
                    sync2_q[gi] <= 1'b0;
                    sync3_q[gi] <= 1'b0;
                    filt_q[gi]  <= 1'b0;
                end else begin
                    sync1_q[gi] <= async_in[gi];
                    sync2_q[gi] <= sync1_q[gi];
                    sync3_q[gi] <= sync2_q[gi];
                    filt_q[gi]  <= filt_d[gi];
                end
            end
        end
    endgenerate

    // Clock watchdog: too few system cycles per reference half period
    logic [WD_CNT_W-1:0] wd_cnt_q;
    logic [WD_CNT_W-1:0] wd_cnt_d;
    logic                wd_ref_q;
    logic                wd_fault_q;
    logic                wd_fault_d;

    // Fault holds from a short interval to the next full one, so severe mode
    // lasts as long as the clock runs slow; a stopped clock is not seen here
    always_comb begin
        wd_fault_d = wd_fault_q;
        wd_cnt_d   = wd_cnt_q;
        if (filt_q[4] != wd_ref_q) begin
            wd_fault_d = (wd_cnt_q < WD_CNT_W'(WD_MIN_CYCLES));
            wd_cnt_d   = '0;
        end else if (wd_cnt_q != '1) begin
            wd_cnt_d = wd_cnt_q + WD_CNT_W'(1);
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            wd_cnt_q   <= '1;
            wd_ref_q   <= 1'b0;
            wd_fault_q <= 1'b0;
        end else begin
            wd_cnt_q   <= wd_cnt_d;
            wd_ref_q   <= filt_q[4];
            wd_fault_q <= wd_fault_d;
        end
    end

    // Live critical conditions
    logic [15:0] crit_live;

    always_comb begin
        crit_live                  = '0;
        crit_live[CRIT_IO_OVER]    = filt_q[0];
        crit_live[CRIT_IO_UNDER]   = filt_q[1];
        crit_live[CRIT_CORE_OVER]  = filt_q[2];
        crit_live[CRIT_CORE_UNDER] = filt_q[3];
        crit_live[CRIT_CLK_FAULT]  = wd_fault_q;
    end

    // Register state
    logic [15:0] g3_status_q, g3_status_d;
    logic [15:0] g3_mask_q,   g3_mask_d;
    logic [15:0] crit_q,      crit_d;
    logic [15:0] forced_q,    forced_d;
    logic        severe_q,    severe_d;
    reg_rsp_s    rsp_q,       rsp_d;
    logic [15:0] rd_mux;
    logic        acc_ok;
    logic        wr_hit;
    logic        rd_hit;
    logic        wr_g3_clear;
    logic        wr_g3_mask;
    logic        wr_crit_clear;
    logic        wr_forced;
    logic        g3_safe;
    logic        forced_on;
    logic        safe_now;

    // Severe mode lasts while any critical condition is present
    assign severe_d  = |(crit_live & CRIT_USED);
    assign forced_on = (forced_q == FORCED_SAFE_KEY);
    assign g3_safe   = |(g3_status_q & ~g3_mask_q);
    assign safe_now  = g3_safe | forced_on | severe_q;
    // Host must keep off the port until recovery; anything sent is dropped
    assign acc_ok    = ~severe_q & ~severe_d;
    assign wr_hit    = acc_ok & reg_req.wr;
    assign rd_hit    = acc_ok & reg_req.rd;

    // One strobe per writable offset; writes elsewhere are ignored
    assign wr_g3_clear   = wr_hit & (reg_req.addr == ADDR_G3_CLEAR);
    assign wr_g3_mask    = wr_hit & (reg_req.addr == ADDR_G3_MASK);
    assign wr_crit_clear = wr_hit & (reg_req.addr == ADDR_CRIT_CLEAR);
    assign wr_forced     = wr_hit & (reg_req.addr == ADDR_FORCED_SAFE);

    // Group-three status and mask
    always_comb begin
        g3_status_d = g3_status_q;
        g3_mask_d   = g3_mask_q;
        // Clear first so that a same-cycle event wins
        if (wr_g3_clear) begin
            g3_status_d = g3_status_d & ~reg_req.wdata;
        end
        if (wr_g3_mask) begin
            g3_mask_d = reg_req.wdata;
        end
        g3_status_d = g3_status_d | g3_fault_in;
        // Critical fault wipes everything but its own status
        if (severe_d) begin
            g3_status_d = STATUS_RESET;
            g3_mask_d   = G3_MASK_RESET;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            g3_status_q <= STATUS_RESET;
            g3_mask_q   <= G3_MASK_RESET;
        end else begin
            g3_status_q <= g3_status_d;
            g3_mask_q   <= g3_mask_d;
        end
    end

    // Critical status survives the wipe; a live condition beats a clear
    always_comb begin
        crit_d = crit_q;
        if (wr_crit_clear) begin
            crit_d = crit_d & ~reg_req.wdata;
        end
        crit_d = crit_d | (crit_live & CRIT_USED);
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            crit_q   <= STATUS_RESET;
            severe_q <= 1'b0;
        end else begin
            crit_q   <= crit_d;
            severe_q <= severe_d;
        end
    end

    // Forced-safe control; a critical wipe also ends forced mode
    always_comb begin
        forced_d = forced_q;
        if (wr_forced) begin
            forced_d = reg_req.wdata;
        end
        if (severe_d) begin
            forced_d = FORCED_SAFE_RESET;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            forced_q <= FORCED_SAFE_RESET;
        end else begin
            forced_q <= forced_d;
        end
    end

    // Read mux; safe status gives the state of the request cycle
    always_comb begin
        rd_mux = '0;
        unique case (reg_req.addr)
            ADDR_G3_STATUS:   rd_mux = g3_status_q;
            ADDR_G3_MASK:     rd_mux = g3_mask_q;
            ADDR_CRIT_STATUS: rd_mux = crit_q;
            ADDR_FORCED_SAFE: rd_mux = forced_q;
            ADDR_SAFE_STATUS: rd_mux[SAFE_BIT] = safe_now;
            default:          rd_mux = '0;
        endcase
    end

    // One-cycle acknowledge; data only with a read, zero otherwise
    always_comb begin
        rsp_d = '0;
        if (wr_hit || rd_hit) begin
            rsp_d.ack = 1'b1;
        end
        if (rd_hit) begin
            rsp_d.rdata = rd_mux;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rsp_q <= '0;
        end else begin
            rsp_q <= rsp_d;
        end
    end

    // Alarm and mode outputs, all registered
    logic alarm_d, alarm_n_d, safe_d, tri_d;
    logic alarm_q, alarm_n_q, safe_q, tri_q;
    logic g3_alarm;

    // Unflagged bits alarm whatever the mask says
    assign g3_alarm = |(g3_status_q & ~(g3_mask_q & G3_FLAGGED));

    always_comb begin
        safe_d = safe_now;
        tri_d  = forced_on & ~severe_q;
        if (severe_q) begin
            alarm_d   = 1'b0;
            alarm_n_d = 1'b0;
        end else begin
            // Latched critical bits keep alarm high after recovery until cleared
            alarm_d   = g3_alarm | (|crit_q);
            alarm_n_d = ~(g3_alarm | (|crit_q));
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            alarm_q   <= 1'b0;
            alarm_n_q <= 1'b1;
            safe_q    <= 1'b0;
            tri_q     <= 1'b0;
        end else begin
            alarm_q   <= alarm_d;
            alarm_n_q <= alarm_n_d;
            safe_q    <= safe_d;
            tri_q     <= tri_d;
        end
    end

    assign alarm_o            = alarm_q;
    assign alarm_n_o          = alarm_n_q;
    assign safe_mode_o        = safe_q;
    assign severe_mode_o      = severe_q;
    assign outputs_tristate_o = tri_q;
    assign reg_rsp            = rsp_q;

endmodule : fault_mask_safe_mode_ctrl
`default_nettype wire

// *** src/fault_safe_pkg.sv ***
package fault_safe_pkg;

    localparam int          ADDR_W   = 12;
    localparam int          DATA_W   = 16;

    // Register offsets
    localparam logic [11:0] ADDR_G3_STATUS     = 12'h103;
    localparam logic [11:0] ADDR_G3_CLEAR      = 12'h107;
    localparam logic [11:0] ADDR_G3_MASK       = 12'h10b;
    localparam logic [11:0] ADDR_CRIT_STATUS   = 12'h10c;
    localparam logic [11:0] ADDR_CRIT_CLEAR    = 12'h10d;
    localparam logic [11:0] ADDR_FORCED_SAFE   = 12'h10e;
    localparam logic [11:0] ADDR_SAFE_STATUS   = 12'h10f;

    // Reset values
    localparam logic [15:0] G3_MASK_RESET      = 16'h0000;
    localparam logic [15:0] FORCED_SAFE_RESET  = 16'h0000;
    localparam logic [15:0] STATUS_RESET       = 16'h0000;

    // Magic value that forces safe mode
    localparam logic [15:0] FORCED_SAFE_KEY    = 16'h00c3;

    // Group-three bits whose mask also gates the alarm: 0..5 and 7
    localparam logic [15:0] G3_FLAGGED         = 16'h00bf;

    // Critical status bit positions
    localparam int          CRIT_IO_OVER       = 0;
    localparam int          CRIT_IO_UNDER      = 1;
    localparam int          CRIT_CLK_FAULT     = 3;
    localparam int          CRIT_CORE_OVER     = 4;
    localparam int          CRIT_CORE_UNDER    = 5;
    localparam logic [15:0] CRIT_USED          = 16'h003b;

    // Safe-mode status bit
    localparam int          SAFE_BIT           = 0;

    // Clock watchdog: reference half period and least system cycles in it
    localparam int          CLK_SYS_MHZ        = 125;
    localparam int          WD_REF_HALF_NS     = 1000;
    localparam int          WD_MIN_NS          = 800;
    localparam int          WD_MIN_CYCLES      = (WD_MIN_NS * CLK_SYS_MHZ) / 1000;
    localparam int          WD_CNT_W           = 10;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [11:0] addr;
        logic [15:0] wdata;
    } reg_req_s;

    typedef struct packed {
        logic        ack;
        logic [15:0] rdata;
    } reg_rsp_s;

endpackage : fault_safe_pkg
